/* rtl/gfcfu_top.sv */
// Form cache lookup, palette justification, interrupt state and fault sequencer.
// Assumes a one-cycle memory write port and a read port answering next cycle.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Palette write takes leftmost descriptor bits
// - Palette read left justifies, zero fills
// - Tag holds descriptor address, form id, key
// - Key is ring segment base value
// - Segments one to seven need key match
// - Segment zero ignores stored key
// - No id match raises cache miss
// - Unused forms may be evicted
// - Interrupt pushes state, sets status bit two
// - Four conditions raise graphics fault
// - Save pointers, cross to segment zero
// - Context block base at octal 32/33
// - Context block ten words in order
// - Restart word zero; one skips instruction
// - Fault code into second accumulator
// - Fault value is user form id
// - Attribute and char faults only at start
// - Other accumulators undefined after fault
// - Block interrupts, jump via octal 30/31
// - Char source needs one rectangle, one bit
// - Overflow sets status flag, continues
module gfcfu_top (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Palette
  input  wire logic        write_palette_op_in,
  input  wire logic        read_palette_op_in,
  input  wire logic [31:0] pal_desc_in,
  output logic      [31:0] pal_desc_out,
  // Form cache load and lookup
  input  wire logic        load_form_op_in,
  input  wire logic [1:0]  load_slot_in,
  input  wire logic [31:0] load_desc_addr_in,
  input  wire logic        lookup_in,
  input  wire logic        evict_unused_in,
  input  wire logic [31:0] second_accumulator_in,
  input  wire logic [31:0] seg_base_in,
  input  wire logic [2:0]  cur_seg_in,
  output logic             hit_out,
  output logic      [31:0] form_desc_addr_out,
  // Instruction events
  input  wire logic        instr_started_in,
  input  wire logic        cursor_hit_in,
  input  wire logic        attr_bad_in,
  input  wire logic        char_blt_in,
  input  wire logic        src_one_rect_in,
  input  wire logic        src_one_bit_in,
  input  wire logic        arith_ovf_in,
  input  wire logic        irq_in,
  input  wire logic        wide_context_pop_op_in,
  // Machine state to save
  input  wire logic [15:0] processor_status_word_in,
  input  wire logic [31:0] first_accumulator_in,
  input  wire logic [31:0] third_accumulator_in,
  input  wire logic [31:0] fourth_accumulator_in,
  input  wire logic        carry_in,
  input  wire logic [30:0] pc_in,
  input  wire logic [31:0] ucode_state_in,
  input  wire logic [31:0] wfp_in,
  input  wire logic [31:0] wsp_in,
  // Memory port
  output logic             mem_wr_out,
  output logic             mem_rd_out,
  output logic      [2:0]  mem_seg_out,
  output logic      [31:0] mem_addr_out,
  output logic      [31:0] mem_wdata_out,
  input  wire logic [31:0] mem_rdata_in,
  // Status and control results
  output logic             interrupted_resume_flag_out,
  output logic             overflow_flag_out,
  output logic             stack_push_out,
  output logic             stack_pop_out,
  output logic             fault_busy_out,
  output logic             jump_out,
  output logic      [31:0] jump_addr_out,
  output logic             irq_block_out,
  output logic             stack_init_out,
  output logic      [31:0] second_accumulator_out
);
  localparam int unsigned N = gfcfu_pkg::CACHE_ENTRIES;
  localparam int unsigned PW = gfcfu_pkg::PAL_WIDTH;
  // ****************************************
  // Palette
  // ****************************************
  logic [PW-1:0] palette_reg;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      palette_reg <= '0;
    end else if (write_palette_op_in) begin
      palette_reg <= pal_desc_in[31 -: PW];
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pal_desc_out <= 32'h0;
    end else if (read_palette_op_in) begin
      pal_desc_out <= {palette_reg, {(32-PW){1'b0}}};
    end
  end
  // ****************************************
  // Form cache
  // ****************************************
  // Tag is three words: descriptor address, form id, key
  logic [31:0] tag_addr_reg [N];
  logic [31:0] tag_id_reg   [N];
  logic [31:0] tag_key_reg  [N];
  logic [N-1:0] valid_reg;
  logic [N-1:0] id_match;
  logic [N-1:0] full_match;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_entry
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          valid_reg[g]   <= 1'b0;
          tag_addr_reg[g] <= 32'h0;
          tag_id_reg[g]   <= 32'h0;
          tag_key_reg[g]  <= 32'h0;
        end else if (load_form_op_in && load_slot_in == 2'(g)) begin
          valid_reg[g]   <= 1'b1;
          tag_addr_reg[g] <= load_desc_addr_in;
          tag_id_reg[g]   <= second_accumulator_in;
          tag_key_reg[g]  <= seg_base_in;
        end else if (evict_unused_in && !full_match[g]) begin
          valid_reg[g] <= 1'b0;
        end
      end
      // Zero id never matches, so a zero form id always misses
      assign id_match[g] = valid_reg[g] && (tag_id_reg[g] == second_accumulator_in)
                           && (second_accumulator_in != 32'h0);
      assign full_match[g] = id_match[g] &&
        ((cur_seg_in == gfcfu_pkg::SEG_ZERO) || (tag_key_reg[g] == seg_base_in));
    end
  endgenerate
  logic [31:0] hit_addr;
  always_comb begin
    hit_addr = 32'h0;
    for (int i = 0; i < N; i++) begin
      if (full_match[i]) begin
        hit_addr = tag_addr_reg[i];
      end
    end
  end
  logic miss_now;
  assign miss_now = lookup_in && (full_match == '0);
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hit_out            <= 1'b0;
      form_desc_addr_out <= 32'h0;
    end else begin
      hit_out            <= lookup_in && (full_match != '0);
      form_desc_addr_out <= hit_addr;
    end
  end
  // ****************************************
  // Fault detection
  // ****************************************
  logic char_bad;
  logic [31:0] code_now;
  logic fault_now;
  gfcfu_pkg::gfcfu_state_type state_reg;
  assign char_bad = char_blt_in && !(src_one_rect_in && src_one_bit_in);
  always_comb begin
    code_now  = 32'h0;
    fault_now = 1'b1;
    if (miss_now) begin
      code_now = gfcfu_pkg::CODE_CACHE_MISS;
    end else if (cursor_hit_in) begin
      code_now = gfcfu_pkg::CODE_CURSOR;
    end else if (attr_bad_in && !instr_started_in) begin
      code_now = gfcfu_pkg::CODE_ATTR;
    end else if (char_bad && !instr_started_in) begin
      code_now = gfcfu_pkg::CODE_CHAR_SRC;
    end else begin
      fault_now = 1'b0;
    end
  end
  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      interrupted_resume_flag_out <= 1'b0;
    end else if (irq_in && state_reg == gfcfu_pkg::GF_IDLE) begin
      interrupted_resume_flag_out <= 1'b1;
    end else if (wide_context_pop_op_in) begin
      interrupted_resume_flag_out <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      overflow_flag_out <= 1'b0;
    end else if (arith_ovf_in) begin
      overflow_flag_out <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stack_push_out <= 1'b0;
      stack_pop_out  <= 1'b0;
    end else begin
      stack_push_out <= irq_in && state_reg == gfcfu_pkg::GF_IDLE;
      stack_pop_out  <= wide_context_pop_op_in;
    end
  end
  // ****************************************
  // Fault sequencer
  // ****************************************
  logic [31:0] code_reg;
  logic [31:0] value_reg;
  logic [31:0] base_reg;
  logic [3:0]  idx_reg;
  logic [31:0] ctx_word;
  always_comb begin
    case (idx_reg)
      4'h0: ctx_word = {16'h0, processor_status_word_in};
      4'h1: ctx_word = first_accumulator_in;
      4'h2: ctx_word = value_reg;
      4'h3: ctx_word = third_accumulator_in;
      4'h4: ctx_word = fourth_accumulator_in;
      4'h5: ctx_word = {pc_in, carry_in};
      4'h6: ctx_word = {29'h0, cur_seg_in};
      4'h7: ctx_word = ucode_state_in;
      4'h8: ctx_word = (code_reg == gfcfu_pkg::CODE_CHAR_SRC) ? 32'h0 : value_reg;
      default: ctx_word = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= gfcfu_pkg::GF_IDLE;
      code_reg  <= 32'h0;
      value_reg <= 32'h0;
      base_reg  <= 32'h0;
      idx_reg   <= 4'h0;
    end else begin
      case (state_reg)
        gfcfu_pkg::GF_IDLE: begin
          idx_reg <= 4'h0;
          if (fault_now) begin
            code_reg  <= code_now;
            value_reg <= second_accumulator_in;
            state_reg <= (cur_seg_in != gfcfu_pkg::SEG_ZERO) ? gfcfu_pkg::GF_SAVE_WFP
                                                             : gfcfu_pkg::GF_RD_BASE;
          end
        end
        gfcfu_pkg::GF_SAVE_WFP: state_reg <= gfcfu_pkg::GF_SAVE_WSP;
        gfcfu_pkg::GF_SAVE_WSP: state_reg <= gfcfu_pkg::GF_RD_BASE;
        gfcfu_pkg::GF_RD_BASE: state_reg <= gfcfu_pkg::GF_WR_CTX;
        gfcfu_pkg::GF_WR_CTX: begin
          if (idx_reg == 4'h0) begin
            base_reg <= mem_rdata_in;
          end
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == gfcfu_pkg::CTX_LAST) begin
            state_reg <= gfcfu_pkg::GF_RD_VEC;
          end
        end
        gfcfu_pkg::GF_RD_VEC: state_reg <= gfcfu_pkg::GF_JUMP;
        gfcfu_pkg::GF_JUMP: state_reg <= gfcfu_pkg::GF_INIT_STK;
        gfcfu_pkg::GF_INIT_STK: state_reg <= gfcfu_pkg::GF_IDLE;
        default: state_reg <= gfcfu_pkg::GF_IDLE;
      endcase
    end
  end
  // First context word uses the base arriving this cycle
  logic [31:0] ctx_base;
  assign ctx_base = (idx_reg == 4'h0) ? mem_rdata_in : base_reg;
  always_comb begin
    mem_wr_out    = 1'b0;
    mem_rd_out    = 1'b0;
    mem_seg_out   = gfcfu_pkg::SEG_ZERO;
    mem_addr_out  = 32'h0;
    mem_wdata_out = 32'h0;
    case (state_reg)
      gfcfu_pkg::GF_SAVE_WFP: begin
        mem_wr_out    = 1'b1;
        mem_seg_out   = cur_seg_in;
        mem_addr_out  = gfcfu_pkg::LOC_WFP;
        mem_wdata_out = wfp_in;
      end
      gfcfu_pkg::GF_SAVE_WSP: begin
        mem_wr_out    = 1'b1;
        mem_seg_out   = cur_seg_in;
        mem_addr_out  = gfcfu_pkg::LOC_WSP;
        mem_wdata_out = wsp_in;
      end
      gfcfu_pkg::GF_RD_BASE: begin
        mem_rd_out   = 1'b1;
        mem_addr_out = gfcfu_pkg::LOC_CTX_BASE_LO;
      end
      gfcfu_pkg::GF_WR_CTX: begin
        mem_wr_out    = 1'b1;
        mem_addr_out  = ctx_base + {28'h0, idx_reg};
        mem_wdata_out = ctx_word;
      end
      gfcfu_pkg::GF_RD_VEC: begin
        mem_rd_out   = 1'b1;
        mem_addr_out = gfcfu_pkg::LOC_HANDLER_LO;
      end
      default: mem_wr_out = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      jump_out               <= 1'b0;
      jump_addr_out          <= 32'h0;
      irq_block_out          <= 1'b0;
      stack_init_out         <= 1'b0;
      second_accumulator_out <= 32'h0;
    end else begin
      jump_out       <= state_reg == gfcfu_pkg::GF_JUMP;
      irq_block_out  <= state_reg == gfcfu_pkg::GF_JUMP;
      stack_init_out <= state_reg == gfcfu_pkg::GF_SAVE_WSP || (state_reg == gfcfu_pkg::GF_RD_BASE &&
                        cur_seg_in == gfcfu_pkg::SEG_ZERO);
      if (state_reg == gfcfu_pkg::GF_JUMP) begin
        jump_addr_out <= mem_rdata_in;
      end
      if (state_reg == gfcfu_pkg::GF_RD_BASE) begin
        second_accumulator_out <= code_reg;
      end
    end
  end
  assign fault_busy_out = state_reg != gfcfu_pkg::GF_IDLE;
  // ****************************************
  // Checks
  // ****************************************
  sequence s_ctx_head;
    state_reg == gfcfu_pkg::GF_RD_BASE ##1 state_reg == gfcfu_pkg::GF_WR_CTX [*5];
  endsequence
  sequence s_ctx_tail;
    state_reg == gfcfu_pkg::GF_WR_CTX [*5] ##1 state_reg == gfcfu_pkg::GF_RD_VEC;
  endsequence
  a_ctx_block_len: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(state_reg == gfcfu_pkg::GF_RD_BASE) |-> s_ctx_head ##1 s_ctx_tail)
    else $error("context block not ten words");
  a_jump_after: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_reg == gfcfu_pkg::GF_RD_VEC |-> ##2 jump_out && irq_block_out)
    else $error("handler jump missing");
  a_miss_code: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_reg == gfcfu_pkg::GF_IDLE && miss_now |=> code_reg == gfcfu_pkg::CODE_CACHE_MISS)
    else $error("miss code wrong");
  a_seg_save: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_reg == gfcfu_pkg::GF_IDLE && fault_now && cur_seg_in != gfcfu_pkg::SEG_ZERO
    |=> mem_wr_out && mem_addr_out == gfcfu_pkg::LOC_WFP)
    else $error("pointers not saved");
  a_pal_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    read_palette_op_in |=> pal_desc_out[31-PW:0] == '0)
    else $error("palette low bits not zero");
  a_interrupted_resume_flag_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    irq_in && state_reg == gfcfu_pkg::GF_IDLE |=> interrupted_resume_flag_out && stack_push_out)
    else $error("interrupt state not pushed");
  a_ovf_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    arith_ovf_in |=> overflow_flag_out)
    else $error("overflow flag not set");
  a_late_attr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_reg == gfcfu_pkg::GF_IDLE && instr_started_in && attr_bad_in && !miss_now && !cursor_hit_in
    && !char_bad |=> state_reg == gfcfu_pkg::GF_IDLE)
    else $error("late attribute fault taken");
  a_restart_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_reg == gfcfu_pkg::GF_WR_CTX && idx_reg == gfcfu_pkg::CTX_LAST |-> mem_wdata_out == 32'h0)
    else $error("restart word not zero");
endmodule

/* pkg/gfcfu_pkg.sv */
// Constants for the graphics form cache and fault unit.
// Assumes a 32-bit word machine with four accumulators and eight segments.
package gfcfu_pkg;
  localparam int unsigned CACHE_ENTRIES = 4;
  localparam int unsigned PAL_WIDTH     = 12;
  localparam int unsigned CTX_WORDS     = 10;
  // Fault codes
  localparam logic [31:0] CODE_CACHE_MISS  = 32'h0000_0005;
  localparam logic [31:0] CODE_CURSOR      = 32'h0000_0006;
  localparam logic [31:0] CODE_ATTR        = 32'h0000_0007;
  localparam logic [31:0] CODE_CHAR_SRC    = 32'h0000_0008;
  // Page zero locations (octal 30, 32, 40, 42)
  localparam logic [31:0] LOC_HANDLER_LO   = 32'h0000_0018;
  localparam logic [31:0] LOC_CTX_BASE_LO  = 32'h0000_001a;
  localparam logic [31:0] LOC_WFP          = 32'h0000_0020;
  localparam logic [31:0] LOC_WSP          = 32'h0000_0022;
  // Status word bits
  localparam int unsigned PSW_OVF_BIT      = 0;
  localparam int unsigned PSW_INTERRUPTED_RESUME_FLAG_BIT     = 2;
  localparam logic [31:0] RESTART_NEXT     = 32'h0000_0001;
  localparam logic [2:0]  SEG_ZERO         = 3'h0;
  localparam logic [3:0]  CTX_LAST         = 4'h9;
  typedef enum logic [3:0] {
    GF_IDLE, GF_SAVE_WFP, GF_SAVE_WSP, GF_RD_BASE, GF_WR_CTX, GF_RD_VEC, GF_JUMP, GF_INIT_STK
  } gfcfu_state_type;
endpackage

/* bench/tb_top.sv */
// Self-checking bench for the form cache and fault unit.
// Assumes memory answers the unit's reads next cycle; the bench plays the memory.
`timescale 1ns/1ps
module tb_top;
  // ****
  // Signals
  // ****
  localparam logic [31:0] CTX_BASE = 32'h0000_0400;
  localparam logic [31:0] HANDLER  = 32'h0000_0800;
  logic        ref_clk_in, rst_in, write_palette_op_in, read_palette_op_in, load_form_op_in, lookup_in;
  logic        evict_unused_in, instr_started_in, cursor_hit_in, attr_bad_in, char_blt_in, src_one_rect_in;
  logic        src_one_bit_in, arith_ovf_in, irq_in, wide_context_pop_op_in, carry_in;
  logic [1:0]  load_slot_in;
  logic [2:0]  cur_seg_in, mem_seg_out;
  logic [15:0] processor_status_word_in;
  logic [30:0] pc_in;
  logic [31:0] pal_desc_in, pal_desc_out, load_desc_addr_in, second_accumulator_in, seg_base_in;
  logic [31:0] form_desc_addr_out, first_accumulator_in, third_accumulator_in, fourth_accumulator_in;
  logic [31:0] ucode_state_in, wfp_in, wsp_in, mem_addr_out, mem_wdata_out, jump_addr_out;
  logic [31:0] second_accumulator_out;
  logic [31:0] mem_rdata_in = 32'h0;
  logic        hit_out, mem_wr_out, mem_rd_out, interrupted_resume_flag_out, overflow_flag_out;
  logic        stack_push_out, stack_pop_out, fault_busy_out, jump_out, irq_block_out, stack_init_out;
  logic [67:0] mem_q[$];
  logic [31:0] jaddr;
  logic        jblk;
  int          n_errors, tests_run, njump, ninit, npush, npop;

  gfcfu_top gfcfu_top_inst (
    .ref_clk_in, .rst_in, .write_palette_op_in, .read_palette_op_in, .pal_desc_in, .pal_desc_out,
    .load_form_op_in, .load_slot_in, .load_desc_addr_in, .lookup_in, .evict_unused_in,
    .second_accumulator_in, .seg_base_in, .cur_seg_in, .hit_out, .form_desc_addr_out,
    .instr_started_in, .cursor_hit_in, .attr_bad_in, .char_blt_in, .src_one_rect_in, .src_one_bit_in,
    .arith_ovf_in, .irq_in, .wide_context_pop_op_in, .processor_status_word_in, .first_accumulator_in,
    .third_accumulator_in, .fourth_accumulator_in, .carry_in, .pc_in, .ucode_state_in, .wfp_in, .wsp_in,
    .mem_wr_out, .mem_rd_out, .mem_seg_out, .mem_addr_out, .mem_wdata_out, .mem_rdata_in,
    .interrupted_resume_flag_out, .overflow_flag_out, .stack_push_out, .stack_pop_out, .fault_busy_out,
    .jump_out, .jump_addr_out, .irq_block_out, .stack_init_out, .second_accumulator_out);

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // ****
  // Memory and monitor
  // ****
  // Unselected read data toggles so a stale value never passes
  always @(posedge ref_clk_in) begin
    if (mem_rd_out === 1'b1) begin
      mem_rdata_in <= (mem_addr_out == gfcfu_pkg::LOC_CTX_BASE_LO) ? CTX_BASE : HANDLER;
    end else begin
      mem_rdata_in <= ~mem_rdata_in;
    end
  end

  always @(posedge ref_clk_in) begin
    if (mem_wr_out === 1'b1 || mem_rd_out === 1'b1) begin
      mem_q.push_back({mem_rd_out, mem_seg_out, mem_addr_out, mem_rd_out ? 32'h0 : mem_wdata_out});
    end
    if (jump_out === 1'b1) begin
      njump++;
      jaddr = jump_addr_out;
      jblk = irq_block_out;
    end
    if (stack_init_out === 1'b1) ninit++;
    if (stack_push_out === 1'b1) npush++;
    if (stack_pop_out === 1'b1) npop++;
  end

  // ****
  // Helpers
  // ****
  task automatic check(input logic [67:0] seen, input logic [67:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic clear_log();
    mem_q.delete();
    njump = 0;
    ninit = 0;
  endtask

  task automatic load(input logic [1:0] slot, input logic [31:0] id, input logic [31:0] key, input logic [31:0] a);
    @(posedge ref_clk_in);
    load_form_op_in <= 1'b1;
    load_slot_in <= slot;
    second_accumulator_in <= id;
    seg_base_in <= key;
    load_desc_addr_in <= a;
    @(posedge ref_clk_in);
    load_form_op_in <= 1'b0;
  endtask

  // Lookup; a hit must name the descriptor address of the loaded form
  task automatic look(input logic [31:0] id, input logic [31:0] key, input logic [2:0] sg, input logic hit_e,
                      input logic [31:0] a);
    @(posedge ref_clk_in);
    clear_log();
    lookup_in <= 1'b1;
    second_accumulator_in <= id;
    seg_base_in <= key;
    cur_seg_in <= sg;
    @(posedge ref_clk_in);
    lookup_in <= 1'b0;
    #1;
    check(hit_out, hit_e, "hit");
    if (hit_e) check(form_desc_addr_out, a, "desc addr");
  endtask

  task automatic event_case(input int k, input logic [2:0] sg, input logic started, input logic rect,
                            input logic bit1);
    @(posedge ref_clk_in);
    clear_log();
    second_accumulator_in <= 32'h0000_0033;
    cur_seg_in <= sg;
    instr_started_in <= started;
    cursor_hit_in <= (k == 1);
    attr_bad_in <= (k == 2);
    char_blt_in <= (k == 3);
    src_one_rect_in <= rect;
    src_one_bit_in <= bit1;
    @(posedge ref_clk_in);
    cursor_hit_in <= 1'b0;
    attr_bad_in <= 1'b0;
    char_blt_in <= 1'b0;
  endtask

  task automatic no_fault();
    repeat (20) @(posedge ref_clk_in);
    check(njump, 0, "unexpected fault jump");
    check(mem_q.size(), 0, "unexpected memory traffic");
  endtask

  // Full fault sequence: pointer saves, context block, vector read and jump
  task automatic chk_fault(input logic [31:0] code, input logic [31:0] val, input logic [2:0] sg);
    logic [67:0] e[$];
    logic [31:0] ctx[10];
    int          i;
    ctx = '{{16'h0, processor_status_word_in}, first_accumulator_in, second_accumulator_in,
            third_accumulator_in, fourth_accumulator_in, {pc_in, carry_in}, {29'h0, sg}, ucode_state_in,
            val, 32'h0};
    if (sg != gfcfu_pkg::SEG_ZERO) begin
      e.push_back({1'b0, sg, gfcfu_pkg::LOC_WFP, wfp_in});
      e.push_back({1'b0, sg, gfcfu_pkg::LOC_WSP, wsp_in});
    end
    e.push_back({1'b1, gfcfu_pkg::SEG_ZERO, gfcfu_pkg::LOC_CTX_BASE_LO, 32'h0});
    for (i = 0; i < gfcfu_pkg::CTX_WORDS; i++) begin
      e.push_back({1'b0, gfcfu_pkg::SEG_ZERO, CTX_BASE + i, ctx[i]});
    end
    e.push_back({1'b1, gfcfu_pkg::SEG_ZERO, gfcfu_pkg::LOC_HANDLER_LO, 32'h0});
    for (i = 0; i < 60 && njump == 0; i++) @(posedge ref_clk_in);
    if (njump == 0) begin
      n_errors++;
      $display("MISMATCH %0t fault jump never came", $time);
      finish_test();
    end
    repeat (2) @(posedge ref_clk_in);
    check(second_accumulator_out, code, "fault code");
    check(jaddr, HANDLER, "handler address");
    check(jblk, 1'b1, "interrupt block");
    check(ninit, 1, "stack init");
    check(fault_busy_out, 1'b0, "busy after jump");
    check(mem_q.size(), e.size(), "memory access count");
    for (i = 0; i < e.size() && i < mem_q.size(); i++) begin
      check(mem_q[i], e[i], "memory access");
    end
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    {rst_in, write_palette_op_in, read_palette_op_in, load_form_op_in, lookup_in, evict_unused_in} = 6'h20;
    {instr_started_in, cursor_hit_in, attr_bad_in, char_blt_in, arith_ovf_in, irq_in} = 6'h00;
    {src_one_rect_in, src_one_bit_in, wide_context_pop_op_in, carry_in} = 4'hd;
    load_slot_in = 2'h0;
    cur_seg_in = 3'h0;
    processor_status_word_in = 16'ha5c3;
    pc_in = 31'h1234_5678;
    {pal_desc_in, load_desc_addr_in, second_accumulator_in, seg_base_in} = 128'h0;
    {first_accumulator_in, third_accumulator_in} = {32'h1111_0000, 32'h3333_0000};
    {fourth_accumulator_in, ucode_state_in} = {32'h4444_0000, 32'h0bad_cafe};
    {wfp_in, wsp_in} = {32'h0000_7100, 32'h0000_7200};
    n_errors = 0;
    tests_run = 0;
    npush = 0;
    npop = 0;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    check({hit_out, jump_out, overflow_flag_out, interrupted_resume_flag_out}, 4'h0, "reset flags");
    check(second_accumulator_out, 32'h0, "reset code");
    // Palette: leftmost bits kept, the rest read back as zero
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk_in);
      pal_desc_in <= (p == 0) ? 32'hffff_ffff : 32'habcd_1234;
      write_palette_op_in <= 1'b1;
      @(posedge ref_clk_in);
      write_palette_op_in <= 1'b0;
      read_palette_op_in <= 1'b1;
      @(posedge ref_clk_in);
      read_palette_op_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      check(pal_desc_out, pal_desc_in & (32'hffff_ffff << (32 - gfcfu_pkg::PAL_WIDTH)), "palette");
    end
    // Cache: key match, key mismatch outside and inside segment zero
    load(2'h0, 32'h0000_0005, 32'h0000_0100, 32'h0000_1000);
    load(2'h1, 32'h0000_0009, 32'h0000_0100, 32'h0000_2000);
    look(32'h0000_0005, 32'h0000_0100, 3'h3, 1'b1, 32'h0000_1000);
    look(32'h0000_0005, 32'h0000_0100, 3'h3, 1'b1, 32'h0000_1000);
    look(32'h0000_0005, 32'h0000_0200, 3'h0, 1'b1, 32'h0000_1000);
    look(32'h0000_0005, 32'h0000_0200, 3'h7, 1'b0, 32'h0);
    chk_fault(gfcfu_pkg::CODE_CACHE_MISS, 32'h0000_0005, 3'h7);
    look(32'h0000_0077, 32'h0000_0100, 3'h1, 1'b0, 32'h0);
    chk_fault(gfcfu_pkg::CODE_CACHE_MISS, 32'h0000_0077, 3'h1);
    // Eviction of an entry the current lookup does not use
    @(posedge ref_clk_in);
    second_accumulator_in <= 32'h0000_0005;
    cur_seg_in <= 3'h3;
    evict_unused_in <= 1'b1;
    @(posedge ref_clk_in);
    evict_unused_in <= 1'b0;
    look(32'h0000_0009, 32'h0000_0100, 3'h3, 1'b0, 32'h0);
    chk_fault(gfcfu_pkg::CODE_CACHE_MISS, 32'h0000_0009, 3'h3);
    look(32'h0000_0005, 32'h0000_0100, 3'h3, 1'b1, 32'h0000_1000);
    // Event faults and their start-only window
    event_case(1, 3'h0, 1'b1, 1'b1, 1'b1);
    chk_fault(gfcfu_pkg::CODE_CURSOR, 32'h0000_0033, 3'h0);
    event_case(2, 3'h5, 1'b1, 1'b1, 1'b1);
    no_fault();
    event_case(2, 3'h5, 1'b0, 1'b1, 1'b1);
    chk_fault(gfcfu_pkg::CODE_ATTR, 32'h0000_0033, 3'h5);
    event_case(3, 3'h0, 1'b0, 1'b1, 1'b1);
    no_fault();
    event_case(3, 3'h0, 1'b0, 1'b0, 1'b1);
    chk_fault(gfcfu_pkg::CODE_CHAR_SRC, 32'h0, 3'h0);
    event_case(3, 3'h2, 1'b0, 1'b1, 1'b0);
    chk_fault(gfcfu_pkg::CODE_CHAR_SRC, 32'h0, 3'h2);
    // Interrupt save and resume
    @(posedge ref_clk_in);
    irq_in <= 1'b1;
    @(posedge ref_clk_in);
    irq_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    check({npush, interrupted_resume_flag_out}, {32'd1, 1'b1}, "interrupt push");
    wide_context_pop_op_in <= 1'b1;
    @(posedge ref_clk_in);
    wide_context_pop_op_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    check({npop, interrupted_resume_flag_out}, {32'd1, 1'b0}, "interrupt pop");
    // Overflow flag is set and stays
    arith_ovf_in <= 1'b1;
    @(posedge ref_clk_in);
    arith_ovf_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    check(overflow_flag_out, 1'b1, "overflow flag");
    finish_test();
  end
endmodule
